/* File: mfpc_pin_model.sv */
// far side of the pin: optional external driver, weak pull-down
`timescale 1ns/10ps
`default_nettype none
module mfpc_pin_model (
  input wire logic ext_drive,
  input wire logic ext_level,
  input wire logic pin_o,
  input wire logic pin_oe_n,
  output logic     pin_i
);
  // the device wins while it drives; a released pin takes the external level, or falls low with no external driver
  assign pin_i = !pin_oe_n ? pin_o : (ext_drive ? ext_level : 1'b0);
endmodule : mfpc_pin_model
`default_nettype wire

/* File: mfpc_pkg.sv */
// constants, codes and register map of the multi-function pin control
// How it works
// - function select zero leaves the pin disabled; zero after reset
// - select 0001 puts the converter word clock on the pin
// - selects 0010 to 0101 output pin clock mux divided by 1, 2, 4, 8
// - select 0110 outputs short-circuit, 0111 noise-gate interrupt
// - select 1000 is general input, 1001 general output
// - select 1011 is serial bus word clock, input or output
// - select 1100 outputs button interrupt, high while pressed after delay
// - select 1101 headset interrupt, 1110 headset OR button
// - select 1111 ORs headset, button, short-circuit and noise-gate
// - clock-source bit picks pll output (0) or divider mux (1)
// - style zero: each pulsed interrupt (selects 0110, 0111, 1101 to 1111) is one high pulse of about 2 ms
// - style one: keep pulsing until host reads the flags register
// - read-only bit reports the present pin level
// - general output mode drives the output-value bit
// - reserved register reads zero; host does not write it
// - flags register holds sticky short, button, headset, noise bits
package mfpc_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RSVD = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  // control register fields
  localparam int CTRL_FUNC_LO = 4;
  localparam int CTRL_CLKSRC = 3;
  localparam int CTRL_STYLE = 2;
  localparam int CTRL_IN_VAL = 1;
  localparam int CTRL_OUT_VAL = 0;
  localparam logic [3:0] CTRL_FUNC_RESET = 4'h0;
  localparam logic [7:0] RSVD_VALUE = 8'h00;
  // event bits, shared by flags, status and mask
  localparam int EV_SHORT = 0;
  localparam int EV_NOISE = 1;
  localparam int EV_HEADSET = 2;
  localparam int EV_BUTTON = 3;
  localparam int EV_N = 4;
  typedef enum logic [3:0] {
    FN_OFF = 4'h0,
    FN_ADC_WCLK = 4'h1,
    FN_DIV1 = 4'h2,
    FN_DIV2 = 4'h3,
    FN_DIV4 = 4'h4,
    FN_DIV8 = 4'h5,
    FN_SHORT = 4'h6,
    FN_NOISE = 4'h7,
    FN_GP_IN = 4'h8,
    FN_GP_OUT = 4'h9,
    FN_RSVD = 4'ha,
    FN_WCLK = 4'hb,
    FN_BUTTON = 4'hc,
    FN_HEADSET = 4'hd,
    FN_HS_BTN = 4'he,
    FN_ALL = 4'hf
  } mfpc_func_t;
  // timing
  localparam int CLK_MHZ = 250;
  localparam int PULSE_MS = 2;
  localparam int BTN_DELAY_US = 500;
  localparam int PULSE_CYC = PULSE_MS * 1000 * CLK_MHZ;
  localparam int BTN_DELAY_CYC = BTN_DELAY_US * CLK_MHZ;
  localparam int CNT_W = 20;
  localparam int DIV_W = 3;
endpackage : mfpc_pkg

/* File: mfpc_pulse.sv */
// interrupt pulse shaper: single pulse or repeated pulses
`timescale 1ns/10ps
`default_nettype none
module mfpc_pulse #(
  parameter logic [19:0] PULSE_CYC = 20'h7_a120
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic trigger,
  input  wire logic continuous,
  input  wire logic pending,
  output logic      pulse
);
  typedef enum logic [2:0] {
    MFPC_IDLE = 3'b001,
    MFPC_HIGH = 3'b010,
    MFPC_LOW  = 3'b100
  } mfpc_pst_t;

  typedef struct packed {
    mfpc_pst_t   st;
    logic [19:0] cnt;
    logic        out;
  } mfpc_pulse_state_t;

  mfpc_pulse_state_t r;
  mfpc_pulse_state_t next_r;

  always_comb begin
    next_r = r;
    if (r.cnt != 20'h0_0000) begin
      next_r.cnt = r.cnt - 20'h0_0001;
    end
    unique case (r.st)
      MFPC_IDLE: begin
        if (trigger || (continuous && pending)) begin
          next_r.st = MFPC_HIGH;
          next_r.cnt = PULSE_CYC - 20'h0_0001;
        end
      end
      MFPC_HIGH: begin
        if (r.cnt == 20'h0_0000) begin
          if (continuous && pending) begin
            next_r.st = MFPC_LOW;
            next_r.cnt = PULSE_CYC - 20'h0_0001;
          end else begin
            next_r.st = MFPC_IDLE;
          end
        end
      end
      MFPC_LOW: begin
        if (r.cnt == 20'h0_0000) begin
          if (continuous && pending) begin
            next_r.st = MFPC_HIGH;
            next_r.cnt = PULSE_CYC - 20'h0_0001;
          end else begin
            next_r.st = MFPC_IDLE;
          end
        end
      end
      default: begin
        next_r.st = MFPC_IDLE;
      end
    endcase
    next_r.out = (next_r.st == MFPC_HIGH);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{st: MFPC_IDLE, cnt: 20'h0_0000, out: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign pulse = r.out;
endmodule : mfpc_pulse
`default_nettype wire

/* File: mfpc_sva.sv */
// port checker for the multi-function pin control
`timescale 1ns/10ps
`default_nettype none
module mfpc_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        short_circuit_evt,
  input wire logic        noise_gate_evt,
  input wire logic        button_level,
  input wire logic        word_clk_drive,
  input wire logic        pin_i,
  input wire logic        pin_o,
  input wire logic        pin_oe_n
);
  logic [7:0] ctl;
  logic [3:0] fn;
  logic [3:0] hist;
  logic       rd;
  assign fn = ctl[7:4];
  assign rd = psel && penable && !pwrite;
  // shadow of the control register, taken at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl  <= 8'h00;
      hist <= 4'h0;
    end else begin
      hist <= {hist[2:0], pin_i};
      if (psel && penable && pwrite && paddr == mfpc_pkg::OFS_CTRL)
        ctl <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  off_hiz_a: assert property (
    fn == 4'h0 && $stable(fn) |-> pin_oe_n && !pin_o)
    else $error("disabled pin is driven");
  gp_in_a: assert property (fn == 4'h8 && $stable(fn) |-> pin_oe_n)
    else $error("input pin is driven");
  gp_out_a: assert property (
    fn == 4'h9 && $stable(ctl) |-> !pin_oe_n && pin_o == ctl[0])
    else $error("output pin differs from output bit");
  wclk_dir_a: assert property (
    fn == 4'hb && $stable(fn) && $stable(word_clk_drive)
    |-> pin_oe_n == !word_clk_drive)
    else $error("word clock direction wrong");
  rsvd_zero_a: assert property (
    rd && paddr == mfpc_pkg::OFS_RSVD |-> prdata == 32'h0)
    else $error("reserved register not zero");
  in_val_a: assert property (
    rd && paddr == mfpc_pkg::OFS_CTRL && hist == {4{pin_i}}
    |-> prdata[1] == pin_i)
    else $error("input value bit differs from pin");
  short_irq_a: assert property (
    fn == 4'h6 && $stable(fn) && short_circuit_evt |-> ##[1:4] pin_o)
    else $error("short circuit interrupt missing");
  all_irq_a: assert property (
    fn == 4'hf && $stable(fn) && noise_gate_evt |-> ##[1:4] pin_o)
    else $error("combined interrupt missing");
  btn_low_a: assert property (
    (fn == 4'hc && !button_level)[*4] |-> !pin_o)
    else $error("button interrupt without press");
  cover property (fn == 4'h6 && short_circuit_evt);
  cover property (fn == 4'hc && pin_o);
  cover property (fn == 4'h9 && pin_o);
endmodule : mfpc_sva
`default_nettype wire

/* File: mfpc_top.sv */
// multi-function pin control with apb register access
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module mfpc_top #(
  parameter logic [19:0] PULSE_CYC     = 20'(mfpc_pkg::PULSE_CYC),
  parameter logic [19:0] BTN_DELAY_CYC = 20'(mfpc_pkg::BTN_DELAY_CYC)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        short_circuit_evt,
  input  wire logic        noise_gate_evt,
  input  wire logic        headset_evt,
  input  wire logic        button_level,
  input  wire logic        pll_clk,
  input  wire logic        clkdiv_clk,
  input  wire logic        adc_word_clk,
  input  wire logic        word_clk,
  input  wire logic        word_clk_drive,
  output logic             word_clk_from_pin,
  input  wire logic        pin_i,
  output logic             pin_o,
  output logic             pin_oe_n
);
  typedef struct packed {
    logic [3:0]  func;
    logic        clksrc;
    logic        style;
    logic        out_val;
    logic        sync1;
    logic        sync2;
    logic [3:0]  flags;
    logic [3:0]  irq_status;
    logic [3:0]  irq_mask;
    logic        src_prev;
    logic [2:0]  div_cnt;
    logic        div1;
    logic        btn_prev;
    logic [19:0] btn_cnt;
    logic        btn_irq;
    logic        ev_trig;
    logic [31:0] rdata;
    logic        err;
    logic        pin_o;
    logic        pin_oe_n;
    logic        wclk_in;
  } mfpc_state_t;

  mfpc_state_t r;
  mfpc_state_t next_r;

  logic       irq_pulse;
  logic [3:0] events;
  logic [3:0] sel_mask;
  logic       setup;
  logic       access;
  logic       src_clk;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == mfpc_pkg::OFS_CTRL) || (a == mfpc_pkg::OFS_RSVD) ||
             (a == mfpc_pkg::OFS_FLAGS) ||
             (a == mfpc_pkg::OFS_IRQ_STATUS) ||
             (a == mfpc_pkg::OFS_IRQ_MASK);
  endfunction : mapped

  // interrupt sources each function routes to the pin
  function automatic logic [3:0] func_sources(input logic [3:0] f);
    logic [3:0] m;
    m = 4'h0;
    unique case (mfpc_pkg::mfpc_func_t'(f))
      mfpc_pkg::FN_SHORT: begin
        m[mfpc_pkg::EV_SHORT] = 1'b1;
      end
      mfpc_pkg::FN_NOISE: begin
        m[mfpc_pkg::EV_NOISE] = 1'b1;
      end
      mfpc_pkg::FN_HEADSET: begin
        m[mfpc_pkg::EV_HEADSET] = 1'b1;
      end
      mfpc_pkg::FN_HS_BTN: begin
        m[mfpc_pkg::EV_HEADSET] = 1'b1;
        m[mfpc_pkg::EV_BUTTON] = 1'b1;
      end
      mfpc_pkg::FN_ALL: begin
        m = 4'hf;
      end
      default: begin
        m = 4'h0;
      end
    endcase
    func_sources = m;
  endfunction : func_sources

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign src_clk = r.clksrc ? clkdiv_clk : pll_clk;
  assign sel_mask = func_sources(r.func);

  always_comb begin
    next_r = r;
    events = 4'h0;

    // two-stage synchroniser on the pin level
    next_r.sync1 = pin_i;
    next_r.sync2 = r.sync1;

    // pin clock mux and divider
    next_r.src_prev = src_clk;
    next_r.div1 = src_clk;
    if (src_clk && !r.src_prev) begin
      next_r.div_cnt = r.div_cnt + 3'h1;
    end

    // button interrupt after the detection delay, held while pressed
    next_r.btn_prev = button_level;
    if (!button_level) begin
      next_r.btn_irq = 1'b0;
      next_r.btn_cnt = 20'h0_0000;
    end else if (!r.btn_prev) begin
      next_r.btn_cnt = BTN_DELAY_CYC;
    end else if (r.btn_cnt == 20'h0_0001) begin
      next_r.btn_irq = 1'b1;
      next_r.btn_cnt = 20'h0_0000;
    end else if (r.btn_cnt != 20'h0_0000) begin
      next_r.btn_cnt = r.btn_cnt - 20'h0_0001;
    end

    events[mfpc_pkg::EV_SHORT] = short_circuit_evt;
    events[mfpc_pkg::EV_NOISE] = noise_gate_evt;
    events[mfpc_pkg::EV_HEADSET] = headset_evt;
    events[mfpc_pkg::EV_BUTTON] = next_r.btn_irq && !r.btn_irq;
    next_r.ev_trig = |(events & sel_mask);

    // apb read data and error taken in the setup cycle
    if (setup) begin
      next_r.err = !mapped(paddr);
      next_r.rdata = 32'h0000_0000;
      unique case (paddr)
        mfpc_pkg::OFS_CTRL: begin
          next_r.rdata[mfpc_pkg::CTRL_FUNC_LO +: 4] = r.func;
          next_r.rdata[mfpc_pkg::CTRL_CLKSRC] = r.clksrc;
          next_r.rdata[mfpc_pkg::CTRL_STYLE] = r.style;
          next_r.rdata[mfpc_pkg::CTRL_IN_VAL] = r.sync2;
          next_r.rdata[mfpc_pkg::CTRL_OUT_VAL] = r.out_val;
        end
        mfpc_pkg::OFS_RSVD: begin
          next_r.rdata[7:0] = mfpc_pkg::RSVD_VALUE;
        end
        mfpc_pkg::OFS_FLAGS: begin
          next_r.rdata[3:0] = r.flags;
        end
        mfpc_pkg::OFS_IRQ_STATUS: begin
          next_r.rdata[3:0] = r.irq_status;
        end
        mfpc_pkg::OFS_IRQ_MASK: begin
          next_r.rdata[3:0] = r.irq_mask;
        end
        default: begin
          next_r.rdata = 32'h0000_0000;
        end
      endcase
    end

    // sticky flags: reading clears, a new event wins
    if (access && !pwrite && paddr == mfpc_pkg::OFS_FLAGS) begin
      next_r.flags = 4'h0;
    end
    next_r.flags = next_r.flags | events;

    // w1c interrupt status, set wins over clear
    if (access && pwrite && paddr == mfpc_pkg::OFS_IRQ_STATUS) begin
      next_r.irq_status = r.irq_status & ~pwdata[3:0];
    end
    next_r.irq_status = next_r.irq_status | events;

    // register writes, reserved register ignores them
    if (access && pwrite) begin
      if (paddr == mfpc_pkg::OFS_CTRL) begin
        next_r.func = pwdata[mfpc_pkg::CTRL_FUNC_LO +: 4];
        next_r.clksrc = pwdata[mfpc_pkg::CTRL_CLKSRC];
        next_r.style = pwdata[mfpc_pkg::CTRL_STYLE];
        next_r.out_val = pwdata[mfpc_pkg::CTRL_OUT_VAL];
      end
      if (paddr == mfpc_pkg::OFS_IRQ_MASK) begin
        next_r.irq_mask = pwdata[3:0];
      end
    end

    // pin drive per function select
    next_r.pin_o = 1'b0;
    next_r.pin_oe_n = 1'b0;
    next_r.wclk_in = 1'b0;
    unique case (mfpc_pkg::mfpc_func_t'(r.func))
      mfpc_pkg::FN_OFF: begin
        next_r.pin_oe_n = 1'b1;
      end
      mfpc_pkg::FN_ADC_WCLK: begin
        next_r.pin_o = adc_word_clk;
      end
      mfpc_pkg::FN_DIV1: begin
        next_r.pin_o = r.div1;
      end
      mfpc_pkg::FN_DIV2: begin
        next_r.pin_o = r.div_cnt[0];
      end
      mfpc_pkg::FN_DIV4: begin
        next_r.pin_o = r.div_cnt[1];
      end
      mfpc_pkg::FN_DIV8: begin
        next_r.pin_o = r.div_cnt[2];
      end
      mfpc_pkg::FN_GP_IN: begin
        next_r.pin_oe_n = 1'b1;
      end
      mfpc_pkg::FN_GP_OUT: begin
        next_r.pin_o = r.out_val;
      end
      mfpc_pkg::FN_RSVD: begin
        next_r.pin_oe_n = 1'b1;
      end
      mfpc_pkg::FN_WCLK: begin
        if (word_clk_drive) begin
          next_r.pin_o = word_clk;
        end else begin
          next_r.pin_oe_n = 1'b1;
          next_r.wclk_in = r.sync2;
        end
      end
      mfpc_pkg::FN_BUTTON: begin
        next_r.pin_o = r.btn_irq;
      end
      mfpc_pkg::FN_SHORT, mfpc_pkg::FN_NOISE,
      mfpc_pkg::FN_HEADSET, mfpc_pkg::FN_HS_BTN,
      mfpc_pkg::FN_ALL: begin
        next_r.pin_o = irq_pulse;
      end
    endcase
  end

  mfpc_pulse #(
    .PULSE_CYC (PULSE_CYC)
  ) u_pulse (
    .pclk       (pclk),
    .presetn    (presetn),
    .trigger    (r.ev_trig),
    .continuous (r.style),
    .pending    (|(r.flags & sel_mask)),
    .pulse      (irq_pulse)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{
        func: mfpc_pkg::CTRL_FUNC_RESET,
        clksrc: 1'b0,
        style: 1'b0,
        out_val: 1'b0,
        sync1: 1'b0,
        sync2: 1'b0,
        flags: 4'h0,
        irq_status: 4'h0,
        irq_mask: 4'h0,
        src_prev: 1'b0,
        div_cnt: 3'h0,
        div1: 1'b0,
        btn_prev: 1'b0,
        btn_cnt: 20'h0_0000,
        btn_irq: 1'b0,
        ev_trig: 1'b0,
        rdata: 32'h0000_0000,
        err: 1'b0,
        pin_o: 1'b0,
        pin_oe_n: 1'b1,
        wclk_in: 1'b0
      };
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.rdata;
  assign pslverr = r.err && access;
  assign pready = 1'b1;
  assign irq = |(r.irq_status & r.irq_mask);
  assign pin_o = r.pin_o;
  assign pin_oe_n = r.pin_oe_n;
  assign word_clk_from_pin = r.wclk_in;
endmodule : mfpc_top
`default_nettype wire

/* File: multi_function_pin_control_tb_top.sv */
// bench for the multi-function pin control
`timescale 1ns/10ps
`default_nettype none
module multi_function_pin_control_tb_top;
  typedef struct packed {
    logic [3:0] fn;
    logic       ov, wd, ed, el, xoe, xo;
  } mfpc_row_t;
  localparam mfpc_row_t ROWS [6] = '{
    '{4'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0},
    '{4'h8, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0},
    '{4'h8, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0},
    '{4'h9, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1},
    '{4'h9, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0},
    '{4'hb, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0}};
  localparam logic [7:0] DCTL [6] = '{8'h20, 8'h30, 8'h40, 8'h50, 8'h28,
                                      8'h10};
  localparam int         DEXP [6] = '{32, 16, 8, 4, 16, 32};
  localparam logic [3:0] IFN [5]  = '{4'h6, 4'h7, 4'hd, 4'he, 4'hf};
  localparam logic [2:0] IEV [5]  = '{3'h4, 3'h2, 3'h1, 3'h1, 3'h2};
  localparam logic [19:0] PULSE   = 20'h0_0010;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        sc, ng, hs, btn, pll, cdiv, wdrv, ext_d, ext_l, err, lvl, ok;
  logic        pin_i, pin_o, oe_n, wfp;
  logic [7:0]  paddr;
  logic [3:0]  div_cnt = 4'h0;
  logic [31:0] pwdata, prdata, rdat;
  mfpc_row_t   r;
  int          fail_count, checks, rises, highs;
  mfpc_top #(.PULSE_CYC(PULSE), .BTN_DELAY_CYC(20'h0_0008)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .short_circuit_evt(sc), .noise_gate_evt(ng), .headset_evt(hs),
    .button_level(btn), .pll_clk(pll), .clkdiv_clk(cdiv),
    .adc_word_clk(pll), .word_clk(cdiv), .word_clk_drive(wdrv),
    .word_clk_from_pin(wfp), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(oe_n));
  mfpc_pin_model far (.ext_drive(ext_d), .ext_level(ext_l),
    .pin_o(pin_o), .pin_oe_n(oe_n), .pin_i(pin_i));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) div_cnt <= div_cnt + 4'h1;
  assign pll  = div_cnt[2];
  assign cdiv = div_cnt[3];
  task automatic chk(input string n, input logic [31:0] e, s);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rdat);
  endtask : rd
  task automatic meas(input int n);
    logic p;
    p = pin_o;
    rises = 0;
    highs = 0;
    repeat (n) begin
      @(posedge pclk);
      rises += int'(pin_o && !p);
      highs += int'(pin_o);
      p = pin_o;
    end
  endtask : meas
  task automatic report_and_stop;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    {presetn, psel, penable, pwrite, sc, ng, hs, btn} = '0;
    {wdrv, ext_d, ext_l} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk("oe_n", 32'h1, 32'(oe_n));
    rd("ctl", mfpc_pkg::OFS_CTRL, 32'h0);
    $display("test reset done");
    foreach (ROWS[i]) begin
      r = ROWS[i];
      {wdrv, ext_d, ext_l} <= {r.wd, r.ed, r.el};
      apb(1'b1, mfpc_pkg::OFS_CTRL, 32'({r.fn, 3'h0, r.ov}));
      repeat (6) @(posedge pclk);
      lvl = r.xoe ? (r.ed & r.el) : r.xo;
      chk("oe_n", 32'(r.xoe), 32'(oe_n));
      chk("pin", 32'(r.xo), 32'(pin_o));
      chk("wclk_in", 32'(r.fn == 4'hb && !r.wd && lvl), 32'(wfp));
      rd("ctl", mfpc_pkg::OFS_CTRL, 32'({r.fn, 2'h0, lvl, r.ov}));
    end
    $display("test modes done");
    apb(1'b1, mfpc_pkg::OFS_FLAGS, 32'hffff_ffff);
    rd("flags", mfpc_pkg::OFS_FLAGS, 32'h0);
    rd("rsvd", mfpc_pkg::OFS_RSVD, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    $display("test map done");
    foreach (DCTL[i]) begin
      apb(1'b1, mfpc_pkg::OFS_CTRL, 32'(DCTL[i]));
      meas(16);
      meas(256);
      ok = rises >= DEXP[i] - 1 && rises <= DEXP[i] + 1;
      chk("div", 32'h1, 32'(ok));
    end
    $display("test clock done");
    foreach (IFN[i]) begin
      apb(1'b1, mfpc_pkg::OFS_CTRL, 32'({IFN[i], 4'h0}));
      @(posedge pclk);
      {sc, ng, hs} <= IEV[i];
      @(posedge pclk);
      {sc, ng, hs} <= 3'h0;
      meas(40);
      chk("pulse", 32'(PULSE), 32'(highs));
      rd("flags", mfpc_pkg::OFS_FLAGS, 32'({IEV[i][0], IEV[i][1], IEV[i][2]}));
    end
    apb(1'b1, mfpc_pkg::OFS_CTRL, 32'h64);
    @(posedge pclk);
    sc <= 1'b1;
    @(posedge pclk);
    sc <= 1'b0;
    meas(80);
    chk("repeat", 32'h1, 32'(rises >= 2));
    rd("flags", mfpc_pkg::OFS_FLAGS, 32'h1);
    meas(40);
    meas(40);
    chk("stopped", 32'h0, 32'(rises));
    $display("test interrupt done");
    rd("status", mfpc_pkg::OFS_IRQ_STATUS, 32'h7);
    chk("irq", 32'h0, 32'(irq));
    apb(1'b1, mfpc_pkg::OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, mfpc_pkg::OFS_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h0, 32'(irq));
    rd("status", mfpc_pkg::OFS_IRQ_STATUS, 32'h6);
    $display("test irq done");
    apb(1'b1, mfpc_pkg::OFS_CTRL, 32'hc0);
    btn <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("btn", 32'h0, 32'(pin_o));
    repeat (10) @(posedge pclk);
    chk("btn", 32'h1, 32'(pin_o));
    btn <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("btn", 32'h0, 32'(pin_o));
    rd("flags", mfpc_pkg::OFS_FLAGS, 32'h8);
    $display("test button done");
    {wdrv, ext_d} <= 2'b10;
    apb(1'b1, mfpc_pkg::OFS_CTRL, 32'hb0);
    meas(8);
    meas(64);
    chk("wclk_oe_n", 32'h0, 32'(oe_n));
    chk("wclk_in", 32'h0, 32'(wfp));
    ok = rises >= 3 && rises <= 5;
    chk("wclk", 32'h1, 32'(ok));
    $display("test word clock done");
    {wdrv, ext_d} <= 2'b00;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("oe_n", 32'h1, 32'(oe_n));
    chk("irq", 32'h0, 32'(irq));
    presetn <= 1'b1;
    rd("ctl", mfpc_pkg::OFS_CTRL, 32'h0);
    rd("status", mfpc_pkg::OFS_IRQ_STATUS, 32'h0);
    $display("test reset again done");
    report_and_stop();
  end
  initial begin
    #100000;
    fail_count++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule : multi_function_pin_control_tb_top
bind mfpc_top mfpc_sva chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .short_circuit_evt(short_circuit_evt),
  .noise_gate_evt(noise_gate_evt), .button_level(button_level),
  .word_clk_drive(word_clk_drive), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe_n(pin_oe_n));
`default_nettype wire
